// ---- pifr_top.sv ----
/*
  Peripheral interrupt request flag registers behind an APB slave, with
  a sticky event status, a mask and one level interrupt output.
  Assumes all peripheral event inputs are single-cycle pulses or levels
  produced by logic on core_clk, so they need no synchroniser.
*/
`default_nettype none
module pifr_top
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // peripheral events
  input  wire logic        adc_done,
  input  wire logic        rx_buffer_full,
  input  wire logic        tx_buffer_empty,
  input  wire logic        ccp_capture,
  input  wire logic        ccp_match,
  input  wire logic        timer2_period_match,
  input  wire logic        timer1_overflow,
  input  wire logic        osc_fail,
  input  wire logic        usb_request,
  input  wire logic        voltage_trip,
  // interrupt
  output logic             irq
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic                              acc_setup;
  logic                              wr_fire;
  logic                              lane0;
  logic [7:0]                        wbyte;
  logic                              hit;
  logic [pifr_pkg::NUM_EVENTS-1:0]   status_reg;
  logic [pifr_pkg::NUM_EVENTS-1:0]   mask_reg;
  pifr_pkg::pifr_ccp_mode_type       ccp_mode_reg;
  logic [7:0]                        flags_a;
  logic [7:0]                        flags_b;
  logic [7:0]                        clr_a;
  logic [7:0]                        clr_b;
  logic                              adc_flag;
  logic                              ccp_flag;
  logic                              timer2_count_flag;
  logic                              timer1_count_flag;
  logic                              osc_flag;
  logic                              usb_flag;
  logic                              hlvd_flag;
  logic                              rx_buffer_full_flag;
  logic                              tx_buffer_empty_flag;
  logic                              ccp_event;
  logic [pifr_pkg::NUM_EVENTS-1:0]   ev_vec;
  logic [pifr_pkg::NUM_EVENTS-1:0]   stat_clr;
  logic [pifr_pkg::NUM_EVENTS-1:0]   status_next;
  logic [31:0]                       rdata_next;
  logic                              rx_prev_reg;
  logic                              tx_prev_reg;

  // the slave answers one cycle after setup: pready rises in the access phase
  assign acc_setup = psel && !penable;
  assign wr_fire   = psel && penable && pready && pwrite;
  assign lane0     = pstrb[0];
  assign wbyte     = pwdata[7:0];

  always_comb
  begin
    unique case (paddr)
      pifr_pkg::OFS_FLAGS_A,
      pifr_pkg::OFS_FLAGS_B,
      pifr_pkg::OFS_STATUS,
      pifr_pkg::OFS_MASK,
      pifr_pkg::OFS_CCP_MODE: hit = 1'b1;
      default:                hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pready <= 1'b0;
    else
      pready <= acc_setup;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pslverr <= 1'b0;
    else
      pslverr <= acc_setup && !hit;
  end

  // ------------------------------------------------------------
  // flag bits
  // ------------------------------------------------------------
  // writing zero to a sticky flag bit clears it; writing one has no effect
  assign clr_a = (wr_fire && lane0 && paddr == pifr_pkg::OFS_FLAGS_A) ?
                 (~wbyte & pifr_pkg::SWCLR_A) : pifr_pkg::RESET_FLAGS;
  assign clr_b = (wr_fire && lane0 && paddr == pifr_pkg::OFS_FLAGS_B) ?
                 (~wbyte & pifr_pkg::IMPL_B) : pifr_pkg::RESET_FLAGS;

  // no enable gates any event input except ccp, whose inputs ccp_mode_reg selects or blocks
  always_comb
  begin
    unique case (ccp_mode_reg)
      pifr_pkg::PIFR_CCP_CAPTURE: ccp_event = ccp_capture;
      pifr_pkg::PIFR_CCP_COMPARE: ccp_event = ccp_match;
      pifr_pkg::PIFR_CCP_PWM:     ccp_event = 1'b0;
      pifr_pkg::PIFR_CCP_OFF:     ccp_event = 1'b0;
    endcase
  end

  pifr_sticky u_adc
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set_in   (adc_done),
    .clr_in   (clr_a[pifr_pkg::BIT_ADC]),
    .flag_reg (adc_flag)
  );

  pifr_sticky u_ccp
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set_in   (ccp_event),
    .clr_in   (clr_a[pifr_pkg::BIT_CCP]),
    .flag_reg (ccp_flag)
  );

  pifr_sticky u_timer2_count
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set_in   (timer2_period_match),
    .clr_in   (clr_a[pifr_pkg::BIT_TIMER2_COUNT]),
    .flag_reg (timer2_count_flag)
  );

  pifr_sticky u_timer1_count
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set_in   (timer1_overflow),
    .clr_in   (clr_a[pifr_pkg::BIT_TIMER1_COUNT]),
    .flag_reg (timer1_count_flag)
  );

  pifr_sticky u_osc
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set_in   (osc_fail),
    .clr_in   (clr_b[pifr_pkg::BIT_OSC]),
    .flag_reg (osc_flag)
  );

  pifr_sticky u_usb
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set_in   (usb_request),
    .clr_in   (clr_b[pifr_pkg::BIT_USB]),
    .flag_reg (usb_flag)
  );

  pifr_sticky u_hlvd
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set_in   (voltage_trip),
    .clr_in   (clr_b[pifr_pkg::BIT_HLVD]),
    .flag_reg (hlvd_flag)
  );

  // serial flags follow buffer state; writes to them are ignored
  assign rx_buffer_full_flag  = rx_buffer_full;
  assign tx_buffer_empty_flag = tx_buffer_empty;

  always_comb
  begin
    flags_a                     = pifr_pkg::RESET_FLAGS;
    flags_a[pifr_pkg::BIT_ADC]  = adc_flag;
    flags_a[pifr_pkg::BIT_RX]   = rx_buffer_full_flag;
    flags_a[pifr_pkg::BIT_TX]   = tx_buffer_empty_flag;
    flags_a[pifr_pkg::BIT_CCP]  = ccp_flag;
    flags_a[pifr_pkg::BIT_TIMER2_COUNT] = timer2_count_flag;
    flags_a[pifr_pkg::BIT_TIMER1_COUNT] = timer1_count_flag;
    flags_b                     = pifr_pkg::RESET_FLAGS;
    flags_b[pifr_pkg::BIT_OSC]  = osc_flag;
    flags_b[pifr_pkg::BIT_USB]  = usb_flag;
    flags_b[pifr_pkg::BIT_HLVD] = hlvd_flag;
  end

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  // rising edges of the serial levels count as events, so a buffer that
  // stays full raises the status only once, and not again after software clears it
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_prev_reg <= 1'b0;
      tx_prev_reg <= 1'b0;
    end
    else
    begin
      rx_prev_reg <= rx_buffer_full;
      tx_prev_reg <= tx_buffer_empty;
    end
  end

  always_comb
  begin
    ev_vec                    = '0;
    ev_vec[pifr_pkg::EV_ADC]  = adc_done;
    ev_vec[pifr_pkg::EV_RX]   = rx_buffer_full && !rx_prev_reg;
    ev_vec[pifr_pkg::EV_TX]   = tx_buffer_empty && !tx_prev_reg;
    ev_vec[pifr_pkg::EV_CCP]  = ccp_event;
    ev_vec[pifr_pkg::EV_TIMER2_COUNT] = timer2_period_match;
    ev_vec[pifr_pkg::EV_TIMER1_COUNT] = timer1_overflow;
    ev_vec[pifr_pkg::EV_OSC]  = osc_fail;
    ev_vec[pifr_pkg::EV_USB]  = usb_request;
    ev_vec[pifr_pkg::EV_HLVD] = voltage_trip;
  end

  assign stat_clr = (wr_fire && paddr == pifr_pkg::OFS_STATUS) ?
                    pwdata[pifr_pkg::NUM_EVENTS-1:0] : '0;
  assign status_next = ev_vec | (status_reg & ~stat_clr);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      mask_reg <= pifr_pkg::RESET_MASK;
    else if (wr_fire && paddr == pifr_pkg::OFS_MASK)
      mask_reg <= pwdata[pifr_pkg::NUM_EVENTS-1:0];
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ccp_mode_reg <= pifr_pkg::PIFR_CCP_OFF;
    else if (wr_fire && lane0 && paddr == pifr_pkg::OFS_CCP_MODE)
      ccp_mode_reg <= pifr_pkg::pifr_ccp_mode_type'(pwdata[1:0]);
  end

  // registered from next state so irq stays a flip-flop and tracks status
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_next = '0;
    unique case (paddr)
      pifr_pkg::OFS_FLAGS_A:  rdata_next[7:0] = flags_a;
      pifr_pkg::OFS_FLAGS_B:  rdata_next[7:0] = flags_b;
      pifr_pkg::OFS_STATUS:   rdata_next[pifr_pkg::NUM_EVENTS-1:0] = status_reg;
      pifr_pkg::OFS_MASK:     rdata_next[pifr_pkg::NUM_EVENTS-1:0] = mask_reg;
      pifr_pkg::OFS_CCP_MODE: rdata_next[1:0] = ccp_mode_reg;
      default:                rdata_next = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= '0;
    else if (acc_setup && !pwrite)
      prdata <= rdata_next;
  end
endmodule
`default_nettype wire

// ---- pifr_pkg.sv ----
/*
  Package for the peripheral interrupt flag block: APB register offsets,
  bit positions of every flag, reset values and capture/compare modes.
  Assumes a 32-bit APB with each register on an aligned word.
*/
`default_nettype none
package pifr_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS_A  = 8'h00;
  localparam logic [7:0] OFS_FLAGS_B  = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_MASK     = 8'h0C;
  localparam logic [7:0] OFS_CCP_MODE = 8'h10;
  // ------------------------------------------------------------
  // flag bit positions
  // ------------------------------------------------------------
  localparam int BIT_ADC   = 6;
  localparam int BIT_RX    = 5;
  localparam int BIT_TX    = 4;
  localparam int BIT_CCP   = 2;
  localparam int BIT_TIMER2_COUNT  = 1;
  localparam int BIT_TIMER1_COUNT  = 0;
  localparam int BIT_OSC   = 7;
  localparam int BIT_USB   = 5;
  localparam int BIT_HLVD  = 2;
  // implemented bits of each flag register
  localparam logic [7:0] IMPL_A = 8'h77;
  localparam logic [7:0] IMPL_B = 8'hA4;
  // software-clearable bits of the first register
  localparam logic [7:0] SWCLR_A = 8'h47;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  // status/mask layout: event index 0..8
  localparam int NUM_EVENTS = 9;
  localparam logic [NUM_EVENTS-1:0] RESET_MASK = 9'h000;
  localparam int EV_ADC  = 0;
  localparam int EV_RX   = 1;
  localparam int EV_TX   = 2;
  localparam int EV_CCP  = 3;
  localparam int EV_TIMER2_COUNT = 4;
  localparam int EV_TIMER1_COUNT = 5;
  localparam int EV_OSC  = 6;
  localparam int EV_USB  = 7;
  localparam int EV_HLVD = 8;
  // ------------------------------------------------------------
  // capture/compare unit modes
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PIFR_CCP_OFF     = 2'h0,
    PIFR_CCP_CAPTURE = 2'h1,
    PIFR_CCP_COMPARE = 2'h2,
    PIFR_CCP_PWM     = 2'h3
  } pifr_ccp_mode_type;
endpackage
`default_nettype wire

// ---- pifr_sticky.sv ----
/*
  One sticky flag bit: set by a hardware event, cleared by software.
  Assumes set and clear are single-cycle signals on core_clk.
*/
`default_nettype none
module pifr_sticky
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // control
  input  wire logic set_in,
  input  wire logic clr_in,
  // state
  output logic      flag_reg
);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      flag_reg <= 1'b0;
    else if (set_in)
      flag_reg <= 1'b1;    // set wins over a same-cycle clear
    else if (clr_in)
      flag_reg <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- pifr_periph_model.sv ----
/*
  Peripheral stand-in for pifr_top: event pulses and serial buffer levels.
  Assumes the bench raises requests on core_clk; each shows one edge later.
*/
`default_nettype none
module pifr_periph_model
(
  // clock
  input  wire logic       core_clk,
  // requests from the bench
  input  wire logic [7:0] ev_req,
  input  wire logic       rx_req,
  input  wire logic       tx_req,
  // peripheral outputs
  output logic      [7:0] ev,
  output logic            rx_buffer_full,
  output logic            tx_buffer_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // events and buffer state
  // ----------------------------------------
  // events fire with no regard to any enable, so the model has none
  always_ff @(posedge core_clk)
  begin
    ev              <= ev_req;
    rx_buffer_full  <= rx_req;
    tx_buffer_empty <= !tx_req;
  end
endmodule
`default_nettype wire

// ---- pifr_top_checker.sv ----
/*
  Checker on the pifr_top ports: apb answer timing, refusals, flag bits.
  Assumes one core_clk domain and the async active-low resetn.
*/
`default_nettype none
module pifr_top_checker
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // serial levels and interrupt
  input  wire logic        rx_buffer_full,
  input  wire logic        tx_buffer_empty,
  input  wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic rd_a;
  logic rd_b;
  assign rd_a = pready && !pwrite && paddr == pifr_pkg::OFS_FLAGS_A;
  assign rd_b = pready && !pwrite && paddr == pifr_pkg::OFS_FLAGS_B;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_ready_one: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_err_high: assert property (pready && paddr > pifr_pkg::OFS_CCP_MODE |-> pslverr)
    else $error("unmapped address not refused");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_unimpl_a: assert property (rd_a |-> (prdata & ~{24'h0, pifr_pkg::IMPL_A}) == 32'h0)
    else $error("unimplemented bits of first flag register set");
  chk_unimpl_b: assert property (rd_b |-> (prdata & ~{24'h0, pifr_pkg::IMPL_B}) == 32'h0)
    else $error("unimplemented bits of second flag register set");
  chk_rx_mirror: assert property (rd_a |-> prdata[pifr_pkg::BIT_RX] == $past(rx_buffer_full))
    else $error("receive flag differs from buffer level");
  chk_tx_mirror: assert property (rd_a |-> prdata[pifr_pkg::BIT_TX] == $past(tx_buffer_empty))
    else $error("transmit flag differs from buffer level");
  cov_adc_read: cover property (rd_a && prdata[pifr_pkg::BIT_ADC]);
  cov_irq_rise: cover property ($rose(irq));
  cov_refused: cover property (pready && pslverr);
endmodule
bind pifr_top pifr_top_checker chk (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .rx_buffer_full, .tx_buffer_empty, .irq);
`default_nettype wire

// ---- peripheral_irq_flag_regs_tb.sv ----
/*
  Bench for pifr_top: apb master tasks, one task per scenario.
  Assumes pifr_periph_model drives the peripheral side.
*/
`default_nettype none
module peripheral_irq_flag_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FA = pifr_pkg::OFS_FLAGS_A;
  localparam logic [7:0] FB = pifr_pkg::OFS_FLAGS_B;
  localparam logic [7:0] ST = pifr_pkg::OFS_STATUS;
  logic        core_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, rx_req = 1'h0, tx_req = 1'h1, err;
  logic        pready, pslverr, irq, rx_buffer_full, tx_buffer_empty;
  logic [7:0]  paddr = '0, ev_req = '0, ev;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0]  pstrb = '0;
  int          errors = 0, n_checks = 0;
  always #2 core_clk = ~core_clk;
  pifr_top uut (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .adc_done(ev[0]), .rx_buffer_full, .tx_buffer_empty,
    .ccp_capture(ev[1]), .ccp_match(ev[2]), .timer2_period_match(ev[3]),
    .timer1_overflow(ev[4]), .osc_fail(ev[5]), .usb_request(ev[6]),
    .voltage_trip(ev[7]), .irq);
  pifr_periph_model periph (.core_clk, .ev_req, .rx_req, .tx_req, .ev, .rx_buffer_full,
    .tx_buffer_empty);
  // ----------------------------------------
  // common tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge core_clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge core_clk);
    penable <= 1'h1;
    for (n = 0; n < 20 && pready !== 1'h1; n++)
      @(posedge core_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 20)
    begin
      errors++;
      $display("wrong value at %0t: no pready", $time);
      stop_test();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, '0, 4'h0);
    check(r, exp);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge core_clk);
    ev_req <= v;
    @(posedge core_clk);
    ev_req <= '0;
  endtask
  task automatic wait_irq(input logic v);
    int n;
    for (n = 0; n < 10 && irq !== v; n++)
      @(posedge core_clk);
    check(irq, v);
    if (n == 10)
      stop_test();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
      rdc(8'(4 * i), '0);
  endtask
  task automatic t_sticky;
    pulse(8'hF9);
    rdc(FA, 32'h43);
    rdc(FB, 32'hA4);
    apb(1'h1, FA, 32'hFF, 4'hF);
    apb(1'h1, FA, '0, 4'h0);
    rdc(FA, 32'h43);
    apb(1'h1, FA, '0, 4'h1);
    apb(1'h1, FB, '0, 4'h1);
    rdc(FA, '0);
    rdc(FB, '0);
  endtask
  task automatic t_ccp;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'h1, pifr_pkg::OFS_CCP_MODE, 32'(m), 4'h1);
      pulse(m == 1 ? 8'h02 : m == 2 ? 8'h04 : 8'h06);
      rdc(FA, (m == 1 || m == 2) ? 32'h4 : 32'h0);
      apb(1'h1, FA, '0, 4'h1);
    end
  endtask
  task automatic t_serial;
    rx_req <= 1'h1;
    rdc(FA, 32'h20);
    apb(1'h1, FA, '0, 4'hF);
    rdc(FA, 32'h20);
    rx_req <= 1'h0;
    tx_req <= 1'h0;
    rdc(FA, 32'h10);
    tx_req <= 1'h1;
    rdc(FA, '0);
  endtask
  task automatic t_race;
    fork
      apb(1'h1, FA, '0, 4'h1);
      pulse(8'h01);
    join
    rdc(FA, 32'h40);
  endtask
  task automatic t_irq;
    // stale status from earlier events is cleared before unmasking
    apb(1'h1, ST, 32'h1FF, 4'hF);
    apb(1'h1, pifr_pkg::OFS_MASK, 32'h1, 4'hF);
    pulse(8'h01);
    wait_irq(1'h1);
    rdc(ST, 32'h1);
    apb(1'h1, ST, 32'h1, 4'hF);
    wait_irq(1'h0);
    pulse(8'h40);
    repeat (3) @(posedge core_clk);
    check(irq, 1'h0);
    rdc(ST, 32'h80);
  endtask
  task automatic t_unmapped;
    rdc(8'h20, '0);
    check(err, 1'h1);
    rdc(FB, 32'h20);
    check(err, 1'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'h1;
    t_reset();
    t_sticky();
    t_ccp();
    t_serial();
    t_race();
    t_irq();
    t_unmapped();
    stop_test();
  end
endmodule
`default_nettype wire
